// ---- prwg_pkg.sv ----
// Constants, encodings and reset values for the protected register write guard.
// Assumes a peripheral store port that is synchronous to the system clock.
package prwg_pkg;

    // ****************************************************************
    // Bus widths and access encodings
    // ****************************************************************
    localparam int        ADDR_W      = 32;
    localparam int        DATA_W      = 16;
    localparam int        REG_W       = 8;
    localparam int        BITNO_W     = 3;

    typedef enum logic [1:0] {
        PRWG_SZ_BYTE = 2'h0,
        PRWG_SZ_HALF = 2'h1,
        PRWG_SZ_WORD = 2'h2,
        PRWG_SZ_BIT  = 2'h3
    } prwg_size_t;

    typedef enum logic [1:0] {
        PRWG_BIT_SET = 2'h0,
        PRWG_BIT_CLR = 2'h1,
        PRWG_BIT_NOT = 2'h2,
        PRWG_BIT_TST = 2'h3
    } prwg_bitop_t;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] STATUS_REG_ADDR     = 32'hfffff078;
    // Unlock and protected register addresses are defaults only
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_DEF     = 32'hfffff1fc;
    localparam logic [ADDR_W-1:0] PWR_SAVE_ADDR_DEF   = 32'hfffff1fe;
    localparam logic [ADDR_W-1:0] CPU_CLK_ADDR_DEF    = 32'hfffff074;
    localparam logic [ADDR_W-1:0] FLASH_MODE_ADDR_DEF = 32'hfffff1bc;

    // Status register layout
    localparam int                ERR_FLAG_BIT        = 4;
    localparam logic [REG_W-1:0]  STATUS_RESET        = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_ZERO          = 16'h0000;

    // One-hot select of the forwarded protected write
    localparam int                NPROT               = 3;
    localparam int                SEL_PWR_SAVE        = 0;
    localparam int                SEL_CPU_CLK         = 1;
    localparam int                SEL_FLASH_MODE      = 2;

endpackage

// ---- prwg_arm_tracker.sv ----
// Single-shot unlock tracker for the protected register write guard.
// Assumes store and service strobes are one-cycle pulses on the system clock.
`timescale 1ns/1ps

module prwg_arm_tracker (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Events
    input  wire logic store_i,
    input  wire logic unlock_wr_i,
    input  wire logic disarm_i,
    // State
    output logic      armed_r_o,
    output logic      armed_eff_o
);

    import prwg_pkg::*;

    typedef enum logic [1:0] {
        PRWG_IDLE  = 2'b01,
        PRWG_ARMED = 2'b10
    } prwg_state_t;

    prwg_state_t state_r;
    prwg_state_t state_nxt;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // A service event in the store's own cycle counts as coming first
    assign armed_eff_o = (state_r == PRWG_ARMED) & ~disarm_i;
    assign armed_r_o   = (state_r == PRWG_ARMED);

    // Any store consumes the arm; only an unlock byte write re-arms
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PRWG_IDLE: begin
                if (store_i && unlock_wr_i) begin
                    state_nxt = PRWG_ARMED;
                end
            end
            PRWG_ARMED: begin
                if (disarm_i) begin
                    state_nxt = PRWG_IDLE;
                end
                if (store_i) begin
                    state_nxt = unlock_wr_i ? PRWG_ARMED : PRWG_IDLE;
                end
            end
            default: begin
                state_nxt = PRWG_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= PRWG_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule

// ---- prwg_guard.sv ----
// Top of the protected register write guard: decodes peripheral stores,
// forwards accepted protected writes and keeps the system status register.
// Assumes every access on the port is a peripheral I/O access, one per pulse.
`timescale 1ns/1ps

module prwg_guard #(
    parameter logic [31:0] UNLOCK_ADDR     = prwg_pkg::UNLOCK_ADDR_DEF,
    parameter logic [31:0] PWR_SAVE_ADDR   = prwg_pkg::PWR_SAVE_ADDR_DEF,
    parameter logic [31:0] CPU_CLK_ADDR    = prwg_pkg::CPU_CLK_ADDR_DEF,
    parameter logic [31:0] FLASH_MODE_ADDR = prwg_pkg::FLASH_MODE_ADDR_DEF
) (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // Peripheral access port
    input  wire logic                              per_req_i,
    input  wire logic                              per_we_i,
    input  wire logic [prwg_pkg::ADDR_W-1:0]       per_addr_i,
    input  wire prwg_pkg::prwg_size_t              per_size_i,
    input  wire prwg_pkg::prwg_bitop_t             per_bitop_i,
    input  wire logic [prwg_pkg::BITNO_W-1:0]      per_bitno_i,
    input  wire logic [prwg_pkg::DATA_W-1:0]       per_wdata_i,
    output logic                                   per_ack_o,
    output logic [prwg_pkg::DATA_W-1:0]            per_rdata_o,
    // Service events that break the unlock sequence
    input  wire logic                              intr_ack_i,
    input  wire logic                              dma_ack_i,
    // Accepted protected write
    output logic                                   prot_wr_o,
    output logic [prwg_pkg::NPROT-1:0]             prot_sel_o,
    output prwg_pkg::prwg_size_t                   prot_size_o,
    output prwg_pkg::prwg_bitop_t                  prot_bitop_o,
    output logic [prwg_pkg::BITNO_W-1:0]           prot_bitno_o,
    output logic [prwg_pkg::REG_W-1:0]             prot_wdata_o,
    // Status
    output logic                                   prot_err_o,
    output logic                                   unlock_armed_o
);

    import prwg_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Full address match, used for every decoded register
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b);
        addr_hit = (a == b);
    endfunction

    logic                 hit_status;
    logic                 hit_unl;
    logic [NPROT-1:0]     hit_prot_vec;
    logic                 hit_prot;
    logic                 is_store;
    logic                 is_bit;
    logic                 is_bit_write;
    logic                 eff_store;
    logic                 unl_byte;
    logic                 armed;
    logic                 disarm;

    // Register selects; three protected registers only
    assign hit_status                   = addr_hit(per_addr_i, STATUS_REG_ADDR);
    assign hit_unl                      = addr_hit(per_addr_i, UNLOCK_ADDR);
    assign hit_prot_vec[SEL_PWR_SAVE]   = addr_hit(per_addr_i, PWR_SAVE_ADDR);
    assign hit_prot_vec[SEL_CPU_CLK]    = addr_hit(per_addr_i, CPU_CLK_ADDR);
    assign hit_prot_vec[SEL_FLASH_MODE] = addr_hit(per_addr_i, FLASH_MODE_ADDR);
    assign hit_prot                = |hit_prot_vec;

    // Access kinds; a bit test is a read, other bit operations are stores
    assign is_bit       = (per_size_i == PRWG_SZ_BIT);
    assign is_bit_write = is_bit & (per_bitop_i != PRWG_BIT_TST);
    assign is_store     = per_req_i & per_we_i;
    assign eff_store    = is_store & (~is_bit | is_bit_write);
    assign unl_byte     = hit_unl & (per_size_i == PRWG_SZ_BYTE);
    assign disarm       = intr_ack_i | dma_ack_i;

    // ****************************************************************
    // Unlock sequence
    // ****************************************************************

    // Reads do not reach the tracker, so they leave the arm alone
    prwg_arm_tracker u_arm (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .store_i     (eff_store),
        .unlock_wr_i (unl_byte),
        .disarm_i    (disarm),
        .armed_r_o   (unlock_armed_o),
        .armed_eff_o (armed)
    );

    // ****************************************************************
    // Classification of stores
    // ****************************************************************
    logic prot_store;
    logic prot_ok;
    logic err_bad_prot;
    logic err_bad_first;
    logic err_set;

    // Protected store is accepted only straight after an unlock
    assign prot_store    = eff_store & hit_prot;
    assign prot_ok       = prot_store & armed;
    assign err_bad_prot  = prot_store & ~armed;
    // Unlock, status or any other unprotected target as first store
    assign err_bad_first = eff_store & armed & ~hit_prot;
    assign err_set       = err_bad_prot | err_bad_first;

    // ****************************************************************
    // System status register
    // ****************************************************************
    logic       err_flag_r;
    logic       err_flag_nxt;
    logic       status_store;
    logic       bit_on_flag;
    logic       clr_by_data;
    logic       clr_by_bit;
    logic       status_clr;

    // Ordinary stores to the status register may clear the flag
    assign status_store = eff_store & hit_status & ~armed;
    assign bit_on_flag  = (per_bitno_i == BITNO_W'(ERR_FLAG_BIT));
    // Byte, halfword and word writes carry the flag in data bit 4
    assign clr_by_data  = ~is_bit & ~per_wdata_i[ERR_FLAG_BIT];
    // Single-bit clear, or invert of a set flag, writes a zero
    assign clr_by_bit   = is_bit_write & bit_on_flag &
                          ((per_bitop_i == PRWG_BIT_CLR) |
                           ((per_bitop_i == PRWG_BIT_NOT) & err_flag_r));
    assign status_clr   = status_store & (clr_by_data | clr_by_bit);

    // Setting outranks clearing, so an error in a clear cycle is kept
    assign err_flag_nxt = err_set ? 1'b1 : (status_clr ? 1'b0 : err_flag_r);

    // Flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_flag_r <= STATUS_RESET[ERR_FLAG_BIT];
        end else begin
            err_flag_r <= err_flag_nxt;
        end
    end

    // ****************************************************************
    // Read path and acknowledge
    // ****************************************************************
    logic                 ack_nxt;
    logic [DATA_W-1:0]    rdata_nxt;
    logic [REG_W-1:0]     status_image;

    // Only bit 4 is live; the rest read as zero
    assign status_image = STATUS_RESET | (REG_W'(err_flag_r) << ERR_FLAG_BIT);
    assign ack_nxt      = per_req_i & (hit_status | hit_unl);
    // Unlock register reads give zero; writes return zero data
    assign rdata_nxt    = (per_req_i & ~per_we_i & hit_status) ?
                          DATA_W'(status_image) : RDATA_ZERO;

    // Answer registers, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_ack_o   <= 1'b0;
            per_rdata_o <= RDATA_ZERO;
        end else begin
            per_ack_o   <= ack_nxt;
            per_rdata_o <= rdata_nxt;
        end
    end

    // Any status read with the flag set reports nonzero at the flag position,
    // whatever the bit number; a bit test reads the byte image above only when per_we_i is low, and reads zero otherwise.

    // ****************************************************************
    // Forwarded protected write
    // ****************************************************************

    // Pulse and payload toward the three protected registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_wr_o    <= 1'b0;
            prot_sel_o   <= '0;
            prot_size_o  <= PRWG_SZ_BYTE;
            prot_bitop_o <= PRWG_BIT_SET;
            prot_bitno_o <= '0;
            prot_wdata_o <= STATUS_RESET;
        end else begin
            prot_wr_o    <= prot_ok;
            prot_sel_o   <= prot_ok ? hit_prot_vec : '0;
            if (prot_ok) begin
                prot_size_o  <= per_size_i;
                prot_bitop_o <= per_bitop_i;
                prot_bitno_o <= per_bitno_i;
                prot_wdata_o <= per_wdata_i[REG_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Status output
    // ****************************************************************

    // Flag copy for the rest of the system
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_err_o <= 1'b0;
        end else begin
            prot_err_o <= err_flag_nxt;
        end
    end

endmodule

// ---- prwg_guard_monitor.sv ----
// Checker of the write guard top ports.
// Assumes it is bound onto every prwg_guard.
`timescale 1ns/1ps

module prwg_guard_monitor #(
    parameter logic [31:0] UNLOCK_ADDR     = prwg_pkg::UNLOCK_ADDR_DEF,
    parameter logic [31:0] PWR_SAVE_ADDR   = prwg_pkg::PWR_SAVE_ADDR_DEF,
    parameter logic [31:0] CPU_CLK_ADDR    = prwg_pkg::CPU_CLK_ADDR_DEF,
    parameter logic [31:0] FLASH_MODE_ADDR = prwg_pkg::FLASH_MODE_ADDR_DEF
) (
    // Clock, reset and access
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  per_req_i,
    input wire logic                  per_we_i,
    input wire logic [31:0]           per_addr_i,
    input wire prwg_pkg::prwg_size_t  per_size_i,
    input wire prwg_pkg::prwg_bitop_t per_bitop_i,
    input wire logic [15:0]           per_wdata_i,
    input wire logic                  intr_ack_i,
    input wire logic                  dma_ack_i,
    // Outputs
    input wire logic                  per_ack_o,
    input wire logic                  prot_wr_o,
    input wire logic [2:0]            prot_sel_o,
    input wire logic                  prot_err_o,
    input wire logic                  unlock_armed_o
);
    import prwg_pkg::*;
    // ****************
    // Access decode
    // ****************
    wire logic tst_w  = per_size_i == PRWG_SZ_BIT && per_bitop_i == PRWG_BIT_TST;
    wire logic st_w   = per_req_i && per_we_i && !tst_w;
    wire logic svc_w  = intr_ack_i || dma_ack_i;
    wire logic prot_w = per_addr_i inside {PWR_SAVE_ADDR, CPU_CLK_ADDR, FLASH_MODE_ADDR};
    wire logic unl_w  = st_w && per_addr_i == UNLOCK_ADDR && per_size_i == PRWG_SZ_BYTE;
    wire logic hit_w  = per_req_i && per_addr_i inside {STATUS_REG_ADDR, UNLOCK_ADDR};
    wire logic clr_w  = st_w && per_addr_i == STATUS_REG_ADDR && per_size_i != PRWG_SZ_BIT;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack; hit_w |=> per_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_arm; unl_w && !svc_w |=> unlock_armed_o; endproperty
    a_arm: assert property (p_arm) else $error("unlock did not arm");
    property p_ok; unl_w && !svc_w ##1 st_w && prot_w && !svc_w |=> prot_wr_o; endproperty
    a_ok: assert property (p_ok) else $error("write dropped");
    property p_bad; st_w && prot_w && !unlock_armed_o |=> !prot_wr_o && prot_err_o; endproperty
    a_bad: assert property (p_bad) else $error("unarmed write");
    property p_unp; st_w && !prot_w && unlock_armed_o && !svc_w |=> prot_err_o; endproperty
    a_unp: assert property (p_unp) else $error("no error flag");
    property p_svc; st_w && prot_w && svc_w |=> !prot_wr_o; endproperty
    a_svc: assert property (p_svc) else $error("serviced write kept");
    property p_rd; per_req_i && !st_w && !svc_w |=> $stable(prot_err_o) && $stable(unlock_armed_o);
    endproperty
    a_rd: assert property (p_rd) else $error("read changed state");
    property p_one; unlock_armed_o && st_w && !unl_w |=> !unlock_armed_o; endproperty
    a_one: assert property (p_one) else $error("arm not consumed");
    property p_clr; clr_w && !per_wdata_i[4] && !unlock_armed_o |=> !prot_err_o; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_sel; prot_wr_o ? $onehot(prot_sel_o) : prot_sel_o == 3'h0; endproperty
    a_sel: assert property (p_sel) else $error("bad select");
endmodule

bind prwg_guard prwg_guard_monitor #(.UNLOCK_ADDR(UNLOCK_ADDR), .PWR_SAVE_ADDR(PWR_SAVE_ADDR),
    .CPU_CLK_ADDR(CPU_CLK_ADDR), .FLASH_MODE_ADDR(FLASH_MODE_ADDR)) MON (.clk_i, .rst_i, .per_req_i,
    .per_we_i, .per_addr_i, .per_size_i, .per_bitop_i, .per_wdata_i, .intr_ack_i,
    .dma_ack_i, .per_ack_o, .prot_wr_o, .prot_sel_o, .prot_err_o, .unlock_armed_o);

// ---- prwg_cpu_model.sv ----
// Processor and DMA side issuing peripheral accesses.
// Assumes the caller waits 1 ns after idle before its checks.
`timescale 1ns/1ps

module prwg_cpu_model (
    // Clock
    input  wire logic            clk_i,
    // Access and service strobes
    output logic                 req_o,
    output logic                 we_o,
    output logic [31:0]          addr_o,
    output prwg_pkg::prwg_size_t size_o,
    output prwg_pkg::prwg_bitop_t bitop_o,
    output logic [2:0]           bitno_o,
    output logic [15:0]          wdata_o,
    output logic [1:0]           svc_o
);
    import prwg_pkg::*;
    // Quiet bus at time zero
    initial begin
        {req_o, we_o, addr_o, bitno_o, wdata_o, svc_o} = '0;
        size_o = PRWG_SZ_BYTE;
        bitop_o = PRWG_BIT_SET;
    end
    // One access per edge; service only when the scenario asks
    task automatic acc(input logic we, input logic [31:0] a, input prwg_size_t sz,
        input prwg_bitop_t bo, input logic [2:0] bn, input logic [15:0] wd, input logic [1:0] sv);
        @(posedge clk_i);
        {req_o, we_o, addr_o} <= {1'b1, we, a};
        size_o <= sz;
        bitop_o <= bo;
        {bitno_o, wdata_o, svc_o} <= {bn, wd, sv};
    endtask
    // Request and service drop; address and data show the inverse of their last value
    task automatic idle;
        @(posedge clk_i);
        {req_o, svc_o} <= 3'h0;
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
    endtask
endmodule

// ---- protected_register_write_guard_tb_top.sv ----
// Self-checking bench of the protected register write guard.
// Assumes the guard runs with its default register addresses.
`timescale 1ns/1ps

module protected_register_write_guard_tb_top;
    import prwg_pkg::*;
    localparam logic [31:0] UA = UNLOCK_ADDR_DEF;
    localparam logic [31:0] SA = STATUS_REG_ADDR;
    localparam logic [31:0] OA = 32'hfffff2a0;
    localparam logic [31:0] PA = PWR_SAVE_ADDR_DEF;
    localparam logic [31:0] CA = CPU_CLK_ADDR_DEF;
    localparam logic [31:0] FA = FLASH_MODE_ADDR_DEF;
    logic clk_i = 1'b0, rst_i = 1'b1, req, we, ack, wr, err, arm;
    logic [31:0] addr;
    prwg_size_t sz, psz;
    prwg_bitop_t bo, pbo;
    logic [2:0] bn, sel, pbn;
    logic [15:0] wd, rdat;
    logic [7:0] pwd;
    logic [1:0] svc;
    logic exp_arm = 1'b0, exp_err = 1'b0;
    logic [31:0] seed = 32'h13, cyc = 0, atab [8];
    int err_count = 0, comparisons = 0;

    // ****************
    // Clock, partner, design
    // ****************
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    prwg_cpu_model MDL (.clk_i, .req_o(req), .we_o(we), .addr_o(addr), .size_o(sz),
        .bitop_o(bo), .bitno_o(bn), .wdata_o(wd), .svc_o(svc));
    prwg_guard DUT (.clk_i, .rst_i, .per_req_i(req), .per_we_i(we), .per_addr_i(addr),
        .per_size_i(sz), .per_bitop_i(bo), .per_bitno_i(bn), .per_wdata_i(wd),
        .per_ack_o(ack), .per_rdata_o(rdat), .intr_ack_i(svc[0]), .dma_ack_i(svc[1]),
        .prot_wr_o(wr), .prot_sel_o(sel), .prot_size_o(psz), .prot_bitop_o(pbo),
        .prot_bitno_o(pbn), .prot_wdata_o(pwd), .prot_err_o(err), .unlock_armed_o(arm));

    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] onehot_of(input logic [31:0] a);
        return {a == FA, a == CA, a == PA};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (e !== g) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic do_rst();
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        {exp_arm, exp_err} = 2'b00;
    endtask
    // One access, reference update and checks one cycle later
    task automatic op(input logic w, input logic [31:0] a, input prwg_size_t s,
        input prwg_bitop_t b, input logic [2:0] n, input logic [15:0] d, input logic [1:0] v,
        input logic b2b);
        logic st, ae, ew, clr;
        logic [15:0] er;
        st = w && !(s == PRWG_SZ_BIT && b == PRWG_BIT_TST);
        ae = exp_arm && v == 2'b00;
        ew = st && ae && onehot_of(a) != 3'h0;
        er = {11'h0, exp_err, 4'h0};
        clr = s != PRWG_SZ_BIT ? !d[4] : n == 3'h4 && b inside {PRWG_BIT_CLR, PRWG_BIT_NOT};
        clr = clr && st && !ae && a == SA;
        if (st && ((onehot_of(a) != 3'h0) != ae)) exp_err = 1'b1;
        else if (clr) exp_err = 1'b0;
        exp_arm = st ? a == UA && s == PRWG_SZ_BYTE : ae;
        MDL.acc(w, a, s, b, n, d, v);
        if (!b2b) begin
            MDL.idle();
            #1;
            chk("prot_wr", ew, wr);
            chk("prot_sel", ew ? onehot_of(a) : 3'h0, sel);
            if (ew) chk("prot_wdata", d[7:0], pwd);
            if (ew) chk("prot_size", s, psz);
            if (ew) chk("prot_bitop", b, pbo);
            if (ew) chk("prot_bitno", n, pbn);
            chk("prot_err", exp_err, err);
            chk("armed", exp_arm, arm);
            chk("ack", a == SA || a == UA, ack);
            if (!w && a == SA) chk("rdata", er, rdat);
        end
    endtask
    task automatic un(input logic b2b);
        op(1, UA, PRWG_SZ_BYTE, PRWG_BIT_SET, 0, 16'h00a5, 0, b2b);
    endtask
    task automatic st(input logic [31:0] a, input logic [15:0] d);
        op(1, a, PRWG_SZ_BYTE, PRWG_BIT_SET, 0, d, 0, 0);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Corner cases first, then random traffic
    initial begin
        logic [31:0] r;
        atab = '{UA, UA, SA, SA, PA, CA, FA, OA};
        do_rst();
        op(0, SA, PRWG_SZ_BYTE, PRWG_BIT_SET, 0, 0, 0, 0);
        un(1); st(CA, 16'h0012);
        st(PA, 16'h0003);
        st(SA, 16'h0000);
        un(0); st(SA, 16'h0000);
        st(SA, 16'h0000); un(0); st(OA, 16'h0044); st(SA, 16'h00ef); st(OA, 16'h0007);
        op(1, UA, PRWG_SZ_HALF, PRWG_BIT_SET, 0, 16'h1234, 0, 1); st(CA, 16'h0001);
        un(0); op(0, CA, PRWG_SZ_BYTE, PRWG_BIT_SET, 0, 0, 0, 0);
        op(0, SA, PRWG_SZ_BIT, PRWG_BIT_TST, 4, 0, 0, 0); st(FA, 16'h0001);
        un(0); op(1, PA, PRWG_SZ_BYTE, PRWG_BIT_SET, 0, 16'h0002, 2'b01, 0);
        un(1); un(1); st(CA, 16'h0033);
        for (int k = 0; k < 3; k++) begin
            un(1); op(1, CA, PRWG_SZ_BIT, prwg_bitop_t'(k), 3'(k), 0, 0, 0);
            op(1, SA, PRWG_SZ_BIT, prwg_bitop_t'(k), 4, 0, 0, 0);
        end
        un(0); do_rst(); op(0, SA, PRWG_SZ_BYTE, PRWG_BIT_SET, 0, 0, 0, 0);
        repeat (600) begin
            r = xs();
            op(r[3], atab[r[2:0]], prwg_size_t'(r[5:4]), prwg_bitop_t'(r[7:6]), r[10:8],
                r[31:16], r[3] ? 2'b00 : r[13:12], r[14]);
        end
        un(0);
        end_of_test();
    end
endmodule
